// ---- common/eeprom_access_pkg.sv ----
// package: register map, field layout, keys and timing of the data eeprom access block
package eeprom_access_pkg;

    localparam int unsigned AXI_AW = 8;

    // byte offsets on the axi4-lite bus
    localparam logic [AXI_AW-1:0] ADDRESS_REG_OFS = 8'h00;
    localparam logic [AXI_AW-1:0] DATA_REG_OFS = 8'h04;
    localparam logic [AXI_AW-1:0] CONTROL_REG_OFS = 8'h08;
    localparam logic [AXI_AW-1:0] UNLOCK_REG_OFS = 8'h0C;
    localparam logic [AXI_AW-1:0] IRQ_FLAGS_OFS = 8'h10;
    localparam logic [AXI_AW-1:0] IRQ_CLEAR_OFS = 8'h14;
    localparam logic [AXI_AW-1:0] IRQ_ENABLE_OFS = 8'h18;

    // control register fields, same order as control_type below
    localparam int unsigned READ_STROBE_BIT = 0;
    localparam int unsigned WRITE_LAUNCH_BIT = 1;
    localparam int unsigned STORE_PERMIT_BIT = 2;
    // interrupt flag, clear and enable registers share this layout
    localparam int unsigned STORE_DONE_BIT = 7;

    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned POWERUP_TIME_MS = 72;
    localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned WRITE_TIME_NS = 4000;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    // longest allowed span from first key to launch
    localparam int unsigned SEQ_MAX_CYCLES = 32;

    typedef struct packed {
        logic store_permit_bit;
        logic write_launch;
        logic read_strobe;
    } control_type;

    typedef enum logic [1:0] {
        UL_IDLE,
        UL_FIRST,
        UL_ARMED
    } unlock_state_type;

endpackage : eeprom_access_pkg

// ---- verilog/data_eeprom_access_control.sv ----
// data eeprom access control: axi4-lite registers, unlock guard, write timer and byte array
//
// Contract
// R1 - software sets the address register, then sets read strobe control bit 0
// R2 - the addressed byte appears in the data register on the next cycle
// R3 - data register holds a read value until another read or software write
// R4 - software sets address and data registers before each byte write
// R5 - a write starts only after 55h, then AAh to unlock, then launch
// R6 - an unlock-to-launch span outside the allowed cycle count suppresses the write
// R7 - the launch bit cannot be set while the store permit bit is clear
// R8 - hardware never clears the store permit bit except at power-up
// R9 - clearing store permit does not abort or alter a running write
// R10 - at write end launch clears and store done flag, bit 7, sets
// R11 - software clears the store done flag; hardware never clears it (here the power-up reset also clears it)
// R12 - power-up clears the store permit bit
// R13 - no array write may start while the 72 ms power-up timer runs
// R14 - software should mask interrupts across the unlock and launch sequence
// R15 - software should keep store permit clear except while updating the array
// R16 - the read strobe clears itself once the byte is in the data register
// R17 - unlock register stores nothing; a wrong value or other access resets it
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
module data_eeprom_access_control #(
    parameter int unsigned AW = 7,
    parameter int unsigned WRITE_CYCLES = eeprom_access_pkg::WRITE_CYCLES,
    parameter int unsigned POWERUP_CYCLES = eeprom_access_pkg::POWERUP_CYCLES,
    parameter int unsigned SEQ_MAX = eeprom_access_pkg::SEQ_MAX_CYCLES
) (
    input logic aclk, // 250 MHz clock
    input logic aresetn, // synchronous power-up reset
    input logic ce, // clock enable, freezes all state when low except while aresetn is low
    input logic [eeprom_access_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
    input logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input logic [31:0] s_axi_wdata, // write data
    input logic [3:0] s_axi_wstrb, // write byte strobes
    input logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input logic s_axi_bready, // write response ready
    input logic [eeprom_access_pkg::AXI_AW-1:0] s_axi_araddr, // read address
    input logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input logic s_axi_rready, // read data ready
    output logic irq // level interrupt, enabled store done flag
);

    localparam int unsigned DEPTH = 2 ** AW;
    localparam int unsigned WCW = $clog2(WRITE_CYCLES);
    localparam int unsigned PCW = $clog2(POWERUP_CYCLES + 1);
    localparam int unsigned SCW = $clog2(SEQ_MAX + 2);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] addr;
        logic [7:0] data;
        eeprom_access_pkg::control_type ctrl;
        logic [AW-1:0] wr_addr;
        logic [7:0] wr_data;
        logic [WCW-1:0] wr_cnt;
        logic [PCW-1:0] pwrt_cnt;
        eeprom_access_pkg::unlock_state_type ul;
        logic [SCW-1:0] seq_cnt;
        logic store_done_flag;
        logic irq_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    logic aw_go;
    logic ar_go;
    logic lane0;
    logic [7:0] wdat;
    logic [7:0] rd_byte;
    logic ctrl_hit;
    logic rd_hit;
    logic data_hit;
    logic clr_hit;
    logic wr_last;
    logic launch_ok;

    function automatic logic is_mapped(input logic [eeprom_access_pkg::AXI_AW-1:0] ofs);
        is_mapped = ofs == eeprom_access_pkg::ADDRESS_REG_OFS
            || ofs == eeprom_access_pkg::DATA_REG_OFS
            || ofs == eeprom_access_pkg::CONTROL_REG_OFS
            || ofs == eeprom_access_pkg::UNLOCK_REG_OFS
            || ofs == eeprom_access_pkg::IRQ_FLAGS_OFS
            || ofs == eeprom_access_pkg::IRQ_CLEAR_OFS
            || ofs == eeprom_access_pkg::IRQ_ENABLE_OFS;
    endfunction : is_mapped

    function automatic logic [31:0] to_word(input logic [7:0] b);
        to_word = {24'h000000, b};
    endfunction : to_word

    function automatic logic [7:0] flag_byte(input logic b);
        flag_byte = 8'(b) << eeprom_access_pkg::STORE_DONE_BIT;
    endfunction : flag_byte

    // a bus write needs address and data together; a read waits for its answer to drain
    assign aw_go = ce && aresetn && s_axi_awvalid && s_axi_wvalid && !st_ff.bvalid;
    assign ar_go = ce && aresetn && s_axi_arvalid && !st_ff.rvalid;
    assign s_axi_awready = aw_go;
    assign s_axi_wready = aw_go;
    assign s_axi_arready = ar_go;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign irq = st_ff.store_done_flag && st_ff.irq_en;

    assign lane0 = s_axi_wstrb[0];
    assign wdat = s_axi_wdata[7:0];
    assign rd_byte = st_ff.mem[st_ff.addr];
    assign ctrl_hit = aw_go && lane0 && s_axi_awaddr == eeprom_access_pkg::CONTROL_REG_OFS;
    assign rd_hit = ctrl_hit && wdat[eeprom_access_pkg::READ_STROBE_BIT];
    assign data_hit = aw_go && lane0 && s_axi_awaddr == eeprom_access_pkg::DATA_REG_OFS;
    assign clr_hit = aw_go && lane0 && s_axi_awaddr == eeprom_access_pkg::IRQ_CLEAR_OFS
        && wdat[eeprom_access_pkg::STORE_DONE_BIT];
    assign wr_last = st_ff.wr_cnt == WCW'(WRITE_CYCLES - 1);
    // permit must already stand before the launching write; its own bit does not count
    assign launch_ok = st_ff.ctrl.store_permit_bit && !st_ff.ctrl.write_launch
        && st_ff.pwrt_cnt == '0
        && st_ff.ul == eeprom_access_pkg::UL_ARMED
        && st_ff.seq_cnt <= SCW'(SEQ_MAX);

    always_comb
    begin
        nxt_st = st_ff;
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        // power-up timer runs down once and then stays at zero
        if (st_ff.pwrt_cnt != '0)
        begin
            nxt_st.pwrt_cnt = st_ff.pwrt_cnt - 1'b1;
        end
        // span of the unlock sequence, saturating so a stale one never wraps back in range
        if (st_ff.ul != eeprom_access_pkg::UL_IDLE && st_ff.seq_cnt != '1)
        begin
            nxt_st.seq_cnt = st_ff.seq_cnt + 1'b1;
        end
        if (aw_go)
        begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = is_mapped(s_axi_awaddr) ? eeprom_access_pkg::RESP_OKAY
                : eeprom_access_pkg::RESP_SLVERR;
            nxt_st.ul = eeprom_access_pkg::UL_IDLE; // R17
            if (lane0)
            begin
                case (s_axi_awaddr)
                    eeprom_access_pkg::ADDRESS_REG_OFS:
                    begin
                        nxt_st.addr = wdat[AW-1:0];
                    end
                    eeprom_access_pkg::DATA_REG_OFS:
                    begin
                        nxt_st.data = wdat; // R3
                    end
                    eeprom_access_pkg::CONTROL_REG_OFS:
                    begin
                        // only software moves the permit bit
                        nxt_st.ctrl.store_permit_bit =
                            wdat[eeprom_access_pkg::STORE_PERMIT_BIT]; // R8
                        if (wdat[eeprom_access_pkg::READ_STROBE_BIT])
                        begin
                            // strobe is served at once, so it never reads back set
                            nxt_st.data = rd_byte; // R2 R16
                        end
                        if (wdat[eeprom_access_pkg::WRITE_LAUNCH_BIT] && launch_ok)
                        begin
                            // R5 R6 R7 R13
                            nxt_st.ctrl.write_launch = 1'b1;
                            nxt_st.wr_addr = st_ff.addr;
                            nxt_st.wr_data = st_ff.data;
                            nxt_st.wr_cnt = '0;
                        end
                    end
                    eeprom_access_pkg::UNLOCK_REG_OFS:
                    begin
                        // R17
                        if (st_ff.ul == eeprom_access_pkg::UL_IDLE
                            && wdat == eeprom_access_pkg::UNLOCK_KEY_FIRST)
                        begin
                            nxt_st.ul = eeprom_access_pkg::UL_FIRST;
                            nxt_st.seq_cnt = '0;
                        end
                        else if (st_ff.ul == eeprom_access_pkg::UL_FIRST
                            && wdat == eeprom_access_pkg::UNLOCK_KEY_SECOND)
                        begin
                            nxt_st.ul = eeprom_access_pkg::UL_ARMED;
                        end
                    end
                    eeprom_access_pkg::IRQ_CLEAR_OFS:
                    begin
                        if (wdat[eeprom_access_pkg::STORE_DONE_BIT])
                        begin
                            nxt_st.store_done_flag = 1'b0; // R11
                        end
                    end
                    eeprom_access_pkg::IRQ_ENABLE_OFS:
                    begin
                        nxt_st.irq_en = wdat[eeprom_access_pkg::STORE_DONE_BIT];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
        if (ar_go)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = is_mapped(s_axi_araddr) ? eeprom_access_pkg::RESP_OKAY
                : eeprom_access_pkg::RESP_SLVERR;
            // even a status poll breaks the unlock sequence
            nxt_st.ul = eeprom_access_pkg::UL_IDLE; // R17
            case (s_axi_araddr)
                eeprom_access_pkg::ADDRESS_REG_OFS:
                    nxt_st.rdata = to_word(8'(st_ff.addr));
                eeprom_access_pkg::DATA_REG_OFS:
                    nxt_st.rdata = to_word(st_ff.data);
                eeprom_access_pkg::CONTROL_REG_OFS:
                    nxt_st.rdata = to_word(8'(st_ff.ctrl));
                eeprom_access_pkg::IRQ_FLAGS_OFS:
                    nxt_st.rdata = to_word(flag_byte(st_ff.store_done_flag));
                eeprom_access_pkg::IRQ_ENABLE_OFS:
                    nxt_st.rdata = to_word(flag_byte(st_ff.irq_en));
                default:
                    nxt_st.rdata = '0;
            endcase
        end
        // the running write uses its own latched copy, so permit or register changes
        // cannot touch it; done is applied last so it wins over a same-cycle clear
        if (st_ff.ctrl.write_launch)
        begin
            if (wr_last)
            begin
                nxt_st.mem[st_ff.wr_addr] = st_ff.wr_data; // R9
                nxt_st.ctrl.write_launch = 1'b0; // R10
                nxt_st.store_done_flag = 1'b1; // R10
            end
            else
            begin
                nxt_st.wr_cnt = st_ff.wr_cnt + 1'b1;
            end
        end
        if (!aresetn)
        begin
            // array contents survive reset; everything else restarts
            nxt_st = '0; // R12
            nxt_st.mem = st_ff.mem;
            nxt_st.pwrt_cnt = PCW'(POWERUP_CYCLES); // R13
        end
    end

    always_ff @(posedge aclk)
    begin
        if (ce || !aresetn)
        begin
            st_ff <= nxt_st;
        end
    end

    a_read_fetch: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        rd_hit |=> st_ff.data == $past(rd_byte))
        else $error("read strobe did not load the addressed byte");

    a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        rd_hit |=> !st_ff.ctrl.read_strobe ##1 !st_ff.ctrl.read_strobe)
        else $error("read strobe stayed set");

    a_data_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        !rd_hit && !data_hit |=> $stable(st_ff.data))
        else $error("data register changed without read or write");

    a_launch_unlock: assert property (@(posedge aclk) disable iff (!aresetn) // R5 R6
        $rose(st_ff.ctrl.write_launch) |->
            $past(st_ff.ul) == eeprom_access_pkg::UL_ARMED
            && $past(st_ff.seq_cnt) <= SCW'(SEQ_MAX))
        else $error("write launched without a timely unlock");

    a_launch_permit: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        $rose(st_ff.ctrl.write_launch) |-> $past(st_ff.ctrl.store_permit_bit))
        else $error("write launched with permit clear");

    a_permit_soft: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        $past(aresetn) && $changed(st_ff.ctrl.store_permit_bit) |-> $past(ctrl_hit))
        else $error("permit changed without a control write");

    a_powerup_block: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        $rose(st_ff.ctrl.write_launch) |-> $past(st_ff.pwrt_cnt) == '0)
        else $error("write launched during power-up time");

    a_write_kept: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        st_ff.ctrl.write_launch && !wr_last |=>
            st_ff.ctrl.write_launch && $stable(st_ff.wr_addr) && $stable(st_ff.wr_data))
        else $error("running write was altered");

    a_write_done: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        ce && st_ff.ctrl.write_launch && wr_last |=>
            !st_ff.ctrl.write_launch && st_ff.store_done_flag
            && st_ff.mem[$past(st_ff.wr_addr)] == $past(st_ff.wr_data))
        else $error("write end did not store, clear launch and flag");

    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        st_ff.store_done_flag && !clr_hit |=> st_ff.store_done_flag)
        else $error("store done flag cleared by hardware");

    a_unlock_reset: assert property (@(posedge aclk) disable iff (!aresetn) // R17
        ar_go |=> st_ff.ul == eeprom_access_pkg::UL_IDLE)
        else $error("unlock state survived another access");

    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        st_ff.bvalid && !s_axi_bready |=> st_ff.bvalid && $stable(st_ff.bresp))
        else $error("write response dropped before bready");

    a_permit_reset: assert property (@(posedge aclk) // R12
        !aresetn |=> !st_ff.ctrl.store_permit_bit)
        else $error("permit survived power-up reset");

    a_done_source: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        $rose(st_ff.store_done_flag) |-> $fell(st_ff.ctrl.write_launch))
        else $error("store done flag set without a finished write");

    a_unlock_break: assert property (@(posedge aclk) disable iff (!aresetn) // R17
        aw_go && !(lane0 && s_axi_awaddr == eeprom_access_pkg::UNLOCK_REG_OFS)
            |=> st_ff.ul == eeprom_access_pkg::UL_IDLE)
        else $error("unlock state survived another write");

endmodule : data_eeprom_access_control

// ---- bench/tb_data_eeprom_access_control.sv ----
// testbench: axi4-lite register checks of the data eeprom access block
module tb_data_eeprom_access_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WCYC = 4;
    localparam int unsigned PUCYC = 32;
    localparam int unsigned LIMIT = 6000;
    localparam logic [7:0] OFS_ADR = eeprom_access_pkg::ADDRESS_REG_OFS;
    localparam logic [7:0] OFS_DAT = eeprom_access_pkg::DATA_REG_OFS;
    localparam logic [7:0] OFS_CTL = eeprom_access_pkg::CONTROL_REG_OFS;
    localparam logic [7:0] OFS_UNL = eeprom_access_pkg::UNLOCK_REG_OFS;
    localparam logic [7:0] OFS_FLG = eeprom_access_pkg::IRQ_FLAGS_OFS;
    localparam logic [7:0] OFS_CLR = eeprom_access_pkg::IRQ_CLEAR_OFS;
    localparam logic [7:0] OFS_ENA = eeprom_access_pkg::IRQ_ENABLE_OFS;
    logic aclk, aresetn, ce, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, a0, d0, a1, d1;
    logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, r;
    logic [3:0] s_axi_wstrb, strb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [33:0] exp_q[$];
    logic [7:0] key1 [6];
    logic [7:0] key2 [6];
    int n_errors, total_checks, cyc;

    data_eeprom_access_control #(.WRITE_CYCLES(WCYC), .POWERUP_CYCLES(PUCYC))
    i_data_eeprom_access_control (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a[1:0] == 2'h0 && a <= OFS_ENA) ? eeprom_access_pkg::RESP_OKAY
                                                : eeprom_access_pkg::RESP_SLVERR;
    endfunction : resp_of

    task automatic chk_word(input string what, input logic [33:0] exp, input logic [33:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk_word

    task automatic chk_irq(input logic exp);
        @(negedge aclk);
        total_checks++;
        if (irq !== exp)
        begin
            $display("ERROR irq expected %b seen %b", exp, irq);
            n_errors++;
        end
    endtask : chk_irq

    // inputs only move right after a rising edge, so the level seen at the
    // falling edge is the one the slave samples at the next rising edge
    task automatic wait_hi(input int sel);
        logic hit;
        do
        begin
            @(negedge aclk);
            hit = (sel == 0) ? s_axi_awready : (sel == 1) ? s_axi_bvalid
                : (sel == 2) ? s_axi_arready : s_axi_rvalid;
            @(posedge aclk);
        end
        while (hit !== 1'b1);
    endtask : wait_hi

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        r = rnd();
        s_axi_awaddr <= a;
        s_axi_wdata <= {r[31:8], d};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // a write with lane 0 masked also holds bready back one cycle
        s_axi_bready <= strb[0];
        exp_q.push_back({resp_of(a), 32'h0000_0000});
        wait_hi(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        if (!strb[0])
            @(posedge aclk);
        s_axi_bready <= 1'b1;
        wait_hi(1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        exp_q.push_back({resp_of(a), 24'h00_0000, (resp_of(a) == 2'h0) ? d : 8'h00});
        wait_hi(2);
        s_axi_arvalid <= 1'b0;
        wait_hi(3);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic ee_store(input logic [7:0] a, input logic [7:0] d);
        wr(OFS_ADR, a);
        wr(OFS_DAT, d);
        wr(OFS_CTL, 8'h04);
        wr(OFS_UNL, 8'h55);
        wr(OFS_UNL, 8'hAA);
        wr(OFS_CTL, 8'h06);
    endtask : ee_store

    task automatic ee_fetch(input logic [7:0] a, input logic [7:0] d);
        wr(OFS_ADR, a);
        // permit stays set so a fetch leaves the control register as found
        wr(OFS_CTL, 8'h05);
        rd(OFS_DAT, d);
        rd(OFS_CTL, 8'h04);
    endtask : ee_fetch

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    always @(negedge aclk)
    begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            chk_word("read", exp_q.size() ? exp_q.pop_front() : 34'h0, {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            chk_word("bresp", exp_q.size() ? exp_q.pop_front() : 34'h0, {s_axi_bresp, 32'h0});
    end

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_errors++;
            close_out();
        end
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        ce = 1'b1;
        strb = 4'hF;
        s_axi_wstrb = 4'hF;
        lfsr = 32'h0001_169C;
        n_errors = 0;
        total_checks = 0;
        cyc = 0;
        key1 = '{8'hAA, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55};
        key2 = '{8'h55, 8'h54, 8'hAA, 8'hAA, 8'hAA, 8'hAA};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // whole sequence lands well inside the power-up window
        ee_store(8'h00, 8'h5A);
        rd(OFS_CTL, 8'h04);
        $display("test powerup done");
        foreach (key1[i])
            rd(8'h04 * i[7:0], (i == 2) ? 8'h04 : (i == 1) ? 8'h5A : 8'h00);
        rd(OFS_ENA, 8'h00);
        rd(8'h1C, 8'h00);
        wr(8'h40, 8'h00);
        $display("test reset_values done");
        r = rnd();
        a0 = {1'b0, r[6:0]};
        d0 = r[15:8];
        ee_store(a0, d0);
        // clock enable low freezes the running write, so it still runs afterwards
        ce <= 1'b0;
        repeat (10) @(posedge aclk);
        ce <= 1'b1;
        rd(OFS_CTL, 8'h06);
        repeat (WCYC + 2) @(posedge aclk);
        rd(OFS_CTL, 8'h04);
        rd(OFS_FLG, 8'h80);
        chk_irq(1'b0);
        wr(OFS_ENA, 8'h80);
        chk_irq(1'b1);
        rd(OFS_ENA, 8'h80);
        wr(OFS_ENA, 8'h00);
        chk_irq(1'b0);
        wr(OFS_ENA, 8'h80);
        ee_fetch(a0, d0);
        rd(OFS_FLG, 8'h80);
        wr(OFS_ADR, a0 ^ 8'h01);
        rd(OFS_DAT, d0);
        wr(OFS_DAT, ~d0);
        rd(OFS_DAT, ~d0);
        wr(OFS_CLR, 8'h80);
        chk_irq(1'b0);
        rd(OFS_FLG, 8'h00);
        $display("test store done");
        a1 = a0 ^ 8'h40;
        d1 = r[23:16];
        ee_store(a1, d1);
        wr(OFS_CTL, 8'h00);
        repeat (WCYC + 2) @(posedge aclk);
        rd(OFS_FLG, 8'h80);
        rd(OFS_CTL, 8'h00);
        wr(OFS_CTL, 8'h04);
        ee_fetch(a1, d1);
        wr(OFS_CLR, 8'h80);
        $display("test permit_drop done");
        // each pass breaks the launch sequence one way; array and flag must not move
        foreach (key1[k])
        begin
            r = rnd();
            wr(OFS_ADR, a0);
            wr(OFS_DAT, r[7:0]);
            wr(OFS_CTL, (k == 5) ? 8'h00 : 8'h04);
            wr(OFS_UNL, key1[k]);
            if (k == 2)
                rd(OFS_FLG, 8'h00);
            if (k == 4)
                repeat (40) @(posedge aclk);
            if (k == 3)
                strb = 4'hE;
            wr(OFS_UNL, key2[k]);
            strb = 4'hF;
            wr(OFS_CTL, (k == 5) ? 8'h02 : 8'h06);
            rd(OFS_CTL, (k == 5) ? 8'h00 : 8'h04);
            repeat (WCYC + 2) @(posedge aclk);
            rd(OFS_FLG, 8'h00);
            wr(OFS_CTL, 8'h04);
            ee_fetch(a0, d0);
            $display("test refused_launch %0d done", k);
        end
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CTL, 8'h00);
        chk_irq(1'b0);
        $display("test second_reset done");
        close_out();
    end
endmodule : tb_data_eeprom_access_control
